// [cttr_consts.vh]
// constants for the safety timer and thermistor control register
`ifndef CTTR_CONSTS_VH
`define CTTR_CONSTS_VH
`define CTTR_REG_ADDR 8'h06
`define CTTR_BIT_SLOW 7
`define CTTR_BIT_LIM_HI 6
`define CTTR_BIT_LIM_LO 5
`define CTTR_BIT_BOOST 4
`define CTTR_BIT_THERM 3
`define CTTR_BIT_FLT_HI 2
`define CTTR_BIT_FLT_LO 1
`define CTTR_BIT_HOLD 0
`define CTTR_RST_SLOW 1'h1
`define CTTR_RST_LIM 2'h0
`define CTTR_RST_BOOST 1'h1
`define CTTR_RST_THERM 1'h1
`define CTTR_RST_HOLD 1'h0
`define CTTR_LIM_SHORT 2'h0
`define CTTR_LIM_6H 2'h1
`define CTTR_LIM_9H 2'h2
`define CTTR_LIM_OFF 2'h3
`define CTTR_FLT_NONE 2'h0
`define CTTR_FLT_SUSPEND 2'h1
`define CTTR_FLT_COOL 2'h2
`define CTTR_FLT_WARM 2'h3
`define CTTR_CLK_HZ 25000000
`define CTTR_LIM_SHORT_MS 75000
`define CTTR_LIM_6H_S 21600
`define CTTR_LIM_9H_S 32400
`define CTTR_BOOST_HI_MA 16'h0fa0
`define CTTR_BOOST_LO_MA 16'h07d0
`define CTTR_HOLD_LO_MV 16'h1068
`define CTTR_HOLD_HI_MV 16'h2774
`define CTTR_HOLD_STEP_PCT 2
`define CTTR_WARM_DROP_MV 16'h0064
`endif

// [cttr_regs.v]
// safety timer / thermistor control register with timer, limits and hold threshold
`timescale 1ns/1ns
`default_nettype none
`include "cttr_consts.vh"
// Operation
// RQ1: register at 06, reset 10011, live fault, 0
// RQ2: slow bit halves timer during regulation states
// RQ3: limit field picks 1.25min/6h/9h/off timer
// RQ4: boost bit picks 4 A or 2 A limit
// RQ5: thermistor enable bit gates monitoring, resets on
// RQ6: fault code reports thermistor band, read only
// RQ7: hold offset bit picks 4.2 V or 10.1 V
// RQ8: bits 7..3 and 0 writable, 2..1 not
// RQ9: hold threshold is offset plus code times 2%
// RQ10: fields hold until write; read shows live fault
module cttr_regs #(
	parameter [47:0] SHORT_CYCLES = 48'd1 * `CTTR_LIM_SHORT_MS * (`CTTR_CLK_HZ / 1000), // 1.25 min in clocks
	parameter [47:0] SIX_H_CYCLES = 48'd1 * `CTTR_LIM_6H_S * `CTTR_CLK_HZ, // 6 h in clocks
	parameter [47:0] NINE_H_CYCLES = 48'd1 * `CTTR_LIM_9H_S * `CTTR_CLK_HZ // 9 h in clocks
) (
	input wire clk, // 25 MHz clock
	input wire sys_rst, // async reset, active high
	input wire [7:0] regAddr, // register location from serial interface
	input wire regWrEn, // one-cycle write strobe
	input wire [7:0] regWrData, // write data
	input wire regRdEn, // one-cycle read strobe
	output reg [7:0] regRdData_r, // read data, valid cycle after strobe
	input wire [1:0] thermistorCode, // live band from thermistor comparators
	input wire inThermalReg, // thermal regulation active
	input wire inInputHold, // input voltage hold active
	input wire inCurrentLimit, // input current limit active
	input wire fastCharging, // fast charge phase running
	input wire [2:0] inputHoldCode, // threshold code from neighbouring register
	output reg safetyExpired_r, // fast charge exceeded its limit
	output wire [15:0] boostLimitMa, // low-side cycle limit in mA
	output wire thermistorMonitorOn, // monitor enable to analog
	output wire [1:0] thermistorFault, // code seen by charge control
	output wire chargeSuspend, // charging halted by temperature
	output wire currentHalved, // cool band current reduction
	output wire [15:0] voltageDropMv, // warm band voltage reduction
	output reg [15:0] inputHoldMv_r // input voltage hold threshold in mV
);
	reg timerSlow_r;
	reg [1:0] safetyLimit_r;
	reg boostSel_r;
	reg thermEn_r;
	reg holdOffSel_r;
	reg [1:0] faultCode_r;
	reg [47:0] timerCount_r;
	reg halfTick_r;
	reg [47:0] limitCycles;
	wire hit;
	wire slowNow;
	wire [15:0] holdBase;
	wire [7:0] regValue;
	wire [7:0] storedValue;
	wire [7:0] liveValue;
	wire wrHit;
	wire timerIdle;
	wire countTick;
	wire [31:0] holdStep;
	wire [15:0] holdNext;
	localparam [7:0] WRITABLE_MASK = 8'hf9;

	assign hit = (regAddr == `CTTR_REG_ADDR); // RQ1
	// monitoring off forces a clean code so charging is not suspended
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			faultCode_r <= `CTTR_FLT_NONE;
		else if (thermEn_r) // RQ5
			faultCode_r <= thermistorCode; // RQ6
		else
			faultCode_r <= `CTTR_FLT_NONE;
	end

	assign storedValue = {timerSlow_r, safetyLimit_r, boostSel_r, thermEn_r, 2'h0, holdOffSel_r};
	assign liveValue = {5'h00, faultCode_r, 1'h0};

	// live fault positions bypass storage so a read shows the present band while monitoring is on, and 00 while it is off
	genvar bitIdx;
	generate
		for (bitIdx = 0; bitIdx < 8; bitIdx = bitIdx + 1)
		begin : g_rd_bit
			assign regValue[bitIdx] = WRITABLE_MASK[bitIdx] ? storedValue[bitIdx] : liveValue[bitIdx]; // RQ10
		end
	endgenerate

	// writes land only at this location; bits 2..1 of the data are dropped
	assign wrHit = regWrEn && hit; // RQ8

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			timerSlow_r <= `CTTR_RST_SLOW; // RQ1
		else if (wrHit)
			timerSlow_r <= regWrData[`CTTR_BIT_SLOW]; // RQ8
	end

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			safetyLimit_r <= `CTTR_RST_LIM; // RQ3
		else if (wrHit)
			safetyLimit_r <= regWrData[`CTTR_BIT_LIM_HI:`CTTR_BIT_LIM_LO]; // RQ8
	end

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			boostSel_r <= `CTTR_RST_BOOST; // RQ4
		else if (wrHit)
			boostSel_r <= regWrData[`CTTR_BIT_BOOST]; // RQ8
	end

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			thermEn_r <= `CTTR_RST_THERM; // RQ5
		else if (wrHit)
			thermEn_r <= regWrData[`CTTR_BIT_THERM]; // RQ8
	end

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			holdOffSel_r <= `CTTR_RST_HOLD; // RQ7
		else if (wrHit)
			holdOffSel_r <= regWrData[`CTTR_BIT_HOLD]; // RQ8
	end

	// read data stands until the next read strobe
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			regRdData_r <= 8'h00;
		else if (regRdEn)
		begin
			if (hit)
				regRdData_r <= regValue; // RQ10
			else
				regRdData_r <= 8'h00; // RQ1
		end
	end

	// timer slowed only while a regulation loop is active
	assign slowNow = timerSlow_r && (inThermalReg || inInputHold || inCurrentLimit); // RQ2
	// counter held at zero while not fast charging or with the timers disabled
	assign timerIdle = !fastCharging || (safetyLimit_r == `CTTR_LIM_OFF); // RQ3
	assign countTick = !slowNow || halfTick_r; // RQ2

	always @*
	begin
		case (safetyLimit_r) // RQ3
			`CTTR_LIM_SHORT: limitCycles = SHORT_CYCLES;
			`CTTR_LIM_6H: limitCycles = SIX_H_CYCLES;
			`CTTR_LIM_9H: limitCycles = NINE_H_CYCLES;
			default: limitCycles = 48'h0;
		endcase
	end

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			halfTick_r <= 1'b0;
		else if (timerIdle)
			halfTick_r <= 1'b0;
		else
			halfTick_r <= ~halfTick_r; // RQ2
	end

	// count stops at the limit so a long charge cannot wrap it
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			timerCount_r <= 48'h0;
		else if (timerIdle)
			timerCount_r <= 48'h0;
		else if (timerCount_r < limitCycles && countTick)
			timerCount_r <= timerCount_r + 48'h1; // RQ3
	end

	// expiry is sticky until charging stops or the limit is turned off
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			safetyExpired_r <= 1'b0;
		else if (timerIdle)
			safetyExpired_r <= 1'b0;
		else if (timerCount_r >= limitCycles)
			safetyExpired_r <= 1'b1; // RQ3
	end

	// boost and monitor controls go straight to the analog side
	assign boostLimitMa = boostSel_r ? `CTTR_BOOST_HI_MA : `CTTR_BOOST_LO_MA; // RQ4
	assign thermistorMonitorOn = thermEn_r; // RQ5

	// band decode seen by charge control
	assign thermistorFault = faultCode_r;
	assign chargeSuspend = (faultCode_r == `CTTR_FLT_SUSPEND); // RQ6
	assign currentHalved = (faultCode_r == `CTTR_FLT_COOL); // RQ6
	assign voltageDropMv = (faultCode_r == `CTTR_FLT_WARM) ? `CTTR_WARM_DROP_MV : 16'h0000; // RQ6
	assign holdBase = holdOffSel_r ? `CTTR_HOLD_HI_MV : `CTTR_HOLD_LO_MV; // RQ7

	// integer millivolts; the 2% step truncates fractions of a millivolt
	assign holdStep = (holdBase * {13'h0, inputHoldCode} * `CTTR_HOLD_STEP_PCT) / 100; // RQ9
	// the largest step is well under 16 bits, so the upper half is always zero
	assign holdNext = holdBase + holdStep[15:0]; // RQ9

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			inputHoldMv_r <= `CTTR_HOLD_LO_MV;
		else
			inputHoldMv_r <= holdNext; // RQ9
	end
endmodule
`default_nettype wire

// [cttr_regs_sva.sv]
// assertions on the control register ports
`timescale 1ns/1ns
`default_nettype none
module cttr_regs_sva (
	input wire logic clk, sys_rst, regWrEn, regRdEn, fastCharging, safetyExpired_r, // control
	input wire logic thermistorMonitorOn, chargeSuspend, currentHalved, // status
	input wire logic [7:0] regAddr, regWrData, regRdData_r, // register port
	input wire logic [1:0] thermistorCode, thermistorFault, // band
	input wire logic [15:0] boostLimitMa, voltageDropMv // limits
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire wr6 = regWrEn && regAddr == 8'h06;
	chk_boost_sel: assert property (wr6 |=> boostLimitMa == ($past(regWrData[4]) ? 16'hfa0 : 16'h7d0))
		else $error("boost");
	chk_monitor_sel: assert property (wr6 |=> thermistorMonitorOn == $past(regWrData[3])) else $error("monitor");
	chk_fault_lag: assert property (thermistorMonitorOn [*2] |-> thermistorFault == $past(thermistorCode))
		else $error("fault");
	chk_fault_off: assert property (!thermistorMonitorOn [*2] |-> thermistorFault == 2'h0) else $error("off");
	chk_band_decode: assert property (chargeSuspend == (thermistorFault == 2'h1)
		&& currentHalved == (thermistorFault == 2'h2) && voltageDropMv == (thermistorFault == 2'h3 ? 16'h64 : 16'h0))
		else $error("band");
	chk_read_back: assert property (wr6 ##1 !regWrEn ##1 regRdEn && regAddr == 8'h06 |=>
		regRdData_r[7:3] == $past(regWrData[7:3], 3)) else $error("readback");
	chk_read_other: assert property (regRdEn && regAddr != 8'h06 |=> regRdData_r == 8'h00) else $error("other");
	chk_expire_clear: assert property (!fastCharging [*2] |-> !safetyExpired_r) else $error("expiry");
	cover property (wr6 && !regWrData[3]);
	cover property (safetyExpired_r);
	cover property (chargeSuspend);
endmodule
bind cttr_regs cttr_regs_sva i_cttr_regs_sva (.*);
`default_nettype wire

// [cttr_host_model.sv]
// host model issuing register strobes
`timescale 1ns/1ns
`default_nettype none
module cttr_host_model (
	input wire logic clk, // clock
	output logic [7:0] regAddr, regWrData, // location, data
	output logic regWrEn, regRdEn, // strobes
	input wire logic [7:0] regRdData_r // read data
);
	initial {regAddr, regWrData, regWrEn, regRdEn} = '0;
	// released data is inverted so a stale byte cannot pass for a fresh one
	task wr(input logic [7:0] a, v);
		@(posedge clk) #1 {regAddr, regWrData, regWrEn} = {a, v, 1'b1};
		@(posedge clk) #1 {regWrData, regWrEn} = {~v, 1'b0};
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk) #1 {regAddr, regRdEn} = {a, 1'b1};
		@(posedge clk) #1 {regRdEn, v} = {1'b0, regRdData_r};
	endtask
endmodule
`default_nettype wire

// [cttr_regs_tb_top.sv]
// bench for the control register
`timescale 1ns/1ns
`default_nettype none
module cttr_regs_tb_top;
	logic clk = 0, sys_rst = 1, inThermalReg = 0, inInputHold = 0, inCurrentLimit = 0, fastCharging = 0;
	logic [1:0] thermistorCode = 2'h3;
	logic [2:0] inputHoldCode = 3'h0;
	logic [7:0] v;
	wire [7:0] regAddr, regWrData, regRdData_r;
	wire regWrEn, regRdEn, safetyExpired_r, thermistorMonitorOn, chargeSuspend, currentHalved;
	wire [1:0] thermistorFault;
	wire [15:0] boostLimitMa, voltageDropMv, inputHoldMv_r;
	int error_cnt = 0, compares = 0;
	cttr_regs #(.SHORT_CYCLES(48'h14), .SIX_H_CYCLES(48'h28), .NINE_H_CYCLES(48'h3c)) i_cttr_regs (.*);
	cttr_host_model i_cttr_host_model (.*);
	initial forever #20 clk = ~clk;
	task chk(input logic [15:0] e, s, input string n);
		compares++;
		error_cnt += (s !== e);
		if (s !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, s);
	endtask
	// limit 11 is passed as 99 cycles, so expiry must never show
	task tmr(input logic [7:0] cfg, input logic [2:0] rg, input int n);
		i_cttr_host_model.wr(8'h06, cfg);
		{inThermalReg, inInputHold, inCurrentLimit, fastCharging} = {rg, 1'b1};
		repeat (n - 3) @(posedge clk);
		#1 chk(16'h0, safetyExpired_r, "early");
		repeat (6) @(posedge clk);
		#1 chk(n < 99, safetyExpired_r, "expiry");
		fastCharging = 0;
	endtask
	task test_done;
		$display("%0d compares %0d mismatches", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		#1 sys_rst = 0;
		i_cttr_host_model.rd(8'h06, v);
		chk(8'h9e, v, "reset");
		chk(16'h0fa0, boostLimitMa, "boost reset");
		chk(16'h1068, inputHoldMv_r, "hold reset");
		chk(16'h0064, voltageDropMv, "warm drop");
		thermistorCode = 2'h0;
		i_cttr_host_model.wr(8'h06, 8'hff);
		i_cttr_host_model.wr(8'h07, 8'h00);
		i_cttr_host_model.rd(8'h06, v);
		chk(8'hf9, v, "bits");
		i_cttr_host_model.rd(8'h07, v);
		chk(8'h00, v, "other");
		thermistorCode = 2'h1;
		i_cttr_host_model.wr(8'h06, 8'h61);
		i_cttr_host_model.rd(8'h06, v);
		chk(8'h61, v, "monitor off");
		chk(16'h07d0, boostLimitMa, "boost low");
		chk(16'h0, thermistorMonitorOn, "monitor");
		chk(16'h0, chargeSuspend, "suspend off");
		for (int k = 0; k < 16; k++)
		begin
			i_cttr_host_model.wr(8'h06, 8'h18 | k[3]);
			inputHoldCode = k[2:0];
			thermistorCode = k[1:0];
			repeat (3) @(posedge clk);
			#1 chk(k[3] ? 16'h2774 + k[2:0] * 16'hca : 16'h1068 + k[2:0] * 16'h54, inputHoldMv_r, "hold");
			chk(k[1:0], thermistorFault, "fault");
			chk(k[1:0] == 2'h1, chargeSuspend, "suspend");
			chk(k[1:0] == 2'h2, currentHalved, "halved");
		end
		$display("register tests done");
		for (int i = 0; i < 4; i++)
			tmr(8'h18 | i << 5, 3'h7, i == 3 ? 99 : 20 * (i + 1));
		tmr(8'h98, 3'h2, 40);
		$display("timer tests done");
		test_done;
	end
endmodule
`default_nettype wire
